// >>> imp_pkg.sv
// shared constants and carrier types for the margin/power-save register port
package imp_pkg;
  localparam logic [6:0] SLAVE_ADDR = 7'h46;
  localparam logic [7:0] IDX_NB = 8'h00;
  localparam logic [7:0] IDX_CORE = 8'h01;
  localparam logic [7:0] IDX_PSAVE = 8'h02;
  localparam logic [7:0] RST_NB = 8'h00;
  localparam logic [7:0] RST_CORE = 8'h00;
  localparam logic [7:0] RST_PSAVE = 8'h01;
  localparam int OVP_BIT = 7;
  localparam int PG_BIT = 6;
  localparam int OFS_MSB = 5;
  localparam int PS_OFS_OFF_BIT = 6;
  localparam int PS_DROP_LSB = 4;
  localparam int PS_ADD_LSB = 2;
  localparam int PS_PH_LSB = 0;
  localparam int OFS_STEP_MV = 25;
  localparam int OVP_LO_MV = 250;
  localparam int OVP_HI_MV = 500;
  localparam int OVP_FLOOR_MV = 1800;
  localparam int PG_CORE_UP_LO_MV = 250;
  localparam int PG_CORE_UP_HI_MV = 300;
  localparam int PG_DN_LO_MV = 300;
  localparam int PG_DN_HI_MV = 350;
  localparam int PG_HYST_MV = 50;
  localparam logic [2:0] STEP_ALL = 3'h0;

  typedef enum logic [1:0] {IMP_SPACE_1, IMP_SPACE_2, IMP_SPACE_4,
                            IMP_SPACE_0} imp_space_t;

  // decoded settings for one regulator
  typedef struct packed {
    logic [11:0] ovp_add_mv;
    logic [11:0] ovp_floor_mv;
    logic [11:0] pg_up_mv;
    logic [11:0] pg_dn_mv;
    logic [11:0] pg_hyst_mv;
    logic signed [11:0] offset_mv;
  } imp_rail_t;

  // decoded power-save settings
  typedef struct packed {
    logic [1:0] phases;
    logic [2:0] drop_cycles;
    logic [2:0] add_cycles;
    logic offset_off;
  } imp_psave_t;
endpackage : imp_pkg

// >>> imp_regs.sv
// two-wire slave port with margin, trip and power-save registers
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// What this block does
// - on read address after restart, ack and shift selected register MSB first.
// - each master ack during read advances to the next register in order, stopping at power-save.
// - power-up values: north bridge 0, core 0, power-save 1.
// - while supply reset is active, all registers are held at initial values.
// - writing the initial values restores defaults, regulation untouched.
// - bit 7 chooses overvoltage trip of +250 or +500 mV, floor 1.8 V.
// - bit 6 chooses power-good window, core +250/-300 or +300/-350.
// - every power-good threshold carries 50 mV hysteresis.
// - bits 5:0 two's-complement offset in 25 mV steps.
// - power-save bits 1:0 choose one, two or three phases.
// - power-save bits 5:4 choose cycles between phase drops.
// - power-save bits 3:2 choose cycles between phase additions.
// - power-save bit 6 suppresses core offset in power savings mode.
// - power-save bit 7 is reserved and affects nothing.
// - index 0 drives north bridge settings, index 1 core settings.
// - respond only to address 1000110, ack by pulling data low.
module imp_regs (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  // supply power-on reset, active high while supply is low
  input wire logic i_supply_por,
  // serial link, open drain
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_oe_n,
  // decoded settings
  output imp_pkg::imp_rail_t o_nb_rail,
  output imp_pkg::imp_rail_t o_core_rail,
  output imp_pkg::imp_psave_t o_psave,
  // raw register view
  output logic [7:0] o_nb_reg,
  output logic [7:0] o_core_reg,
  output logic [7:0] o_psave_reg
);

  typedef enum logic [2:0] {IMP_IDLE, IMP_ADDR, IMP_ADDR_ACK, IMP_RX,
                            IMP_RX_ACK, IMP_TX, IMP_TX_ACK} imp_state_t;

  function automatic imp_pkg::imp_rail_t rail_decode(input logic [7:0] r,
                                                     input logic core);
    imp_pkg::imp_rail_t d;
    d.ovp_floor_mv = 12'(imp_pkg::OVP_FLOOR_MV);
    d.ovp_add_mv = r[imp_pkg::OVP_BIT] ? 12'(imp_pkg::OVP_HI_MV)
                                       : 12'(imp_pkg::OVP_LO_MV);
    d.pg_dn_mv = r[imp_pkg::PG_BIT] ? 12'(imp_pkg::PG_DN_HI_MV)
                                    : 12'(imp_pkg::PG_DN_LO_MV);
    if (!core)
      d.pg_up_mv = 12'h000;
    else if (r[imp_pkg::PG_BIT])
      d.pg_up_mv = 12'(imp_pkg::PG_CORE_UP_HI_MV);
    else
      d.pg_up_mv = 12'(imp_pkg::PG_CORE_UP_LO_MV);
    d.pg_hyst_mv = 12'(imp_pkg::PG_HYST_MV);
    d.offset_mv = 12'($signed({{6{r[imp_pkg::OFS_MSB]}},
                       r[imp_pkg::OFS_MSB:0]}) *
                       imp_pkg::OFS_STEP_MV);
    return d;
  endfunction : rail_decode

  function automatic logic [2:0] space_decode(input logic [1:0] f);
    case (imp_pkg::imp_space_t'(f))
      imp_pkg::IMP_SPACE_1: space_decode = 3'h1;
      imp_pkg::IMP_SPACE_2: space_decode = 3'h2;
      imp_pkg::IMP_SPACE_4: space_decode = 3'h4;
      default: space_decode = imp_pkg::STEP_ALL;
    endcase
  endfunction : space_decode

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and edge detection
  logic [1:0] scl_sync_ff;
  logic [1:0] sda_sync_ff;
  logic [1:0] por_sync_ff;
  logic scl_d_ff;
  logic sda_d_ff;

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_resetn)
    begin
      scl_sync_ff <= 2'h3;
      sda_sync_ff <= 2'h3;
      por_sync_ff <= 2'h3;
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end
    else
    begin
      scl_sync_ff <= {scl_sync_ff[0], i_scl};
      sda_sync_ff <= {sda_sync_ff[0], i_sda};
      por_sync_ff <= {por_sync_ff[0], i_supply_por};
      scl_d_ff <= scl_sync_ff[1];
      sda_d_ff <= sda_sync_ff[1];
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic por_hold;
  assign scl_rise = scl_sync_ff[1] && !scl_d_ff;
  assign scl_fall = !scl_sync_ff[1] && scl_d_ff;
  assign start_seen = scl_sync_ff[1] && scl_d_ff && sda_d_ff
                      && !sda_sync_ff[1];
  assign stop_seen = scl_sync_ff[1] && scl_d_ff && !sda_d_ff
                     && sda_sync_ff[1];
  assign por_hold = !i_resetn || por_sync_ff[1];

  //////////////////////////////////////////////////////////////////////////////
  // protocol engine
  imp_state_t state_ff;
  logic [7:0] shift_ff;
  logic [3:0] bit_cnt_ff;
  logic rd_ff;
  logic idx_phase_ff;
  logic [7:0] ptr_ff;
  logic wr_en;
  logic [7:0] wr_data;
  logic [7:0] nb_ff;
  logic [7:0] core_ff;
  logic [7:0] psave_ff;
  logic sda_oe_n_ff;
  logic [7:0] tx_byte;

  function automatic logic [7:0] reg_sel(input logic [7:0] p,
                                         input logic [7:0] a,
                                         input logic [7:0] b,
                                         input logic [7:0] c);
    if (p == imp_pkg::IDX_NB)
      reg_sel = a;
    else if (p == imp_pkg::IDX_CORE)
      reg_sel = b;
    else
      reg_sel = c;
  endfunction : reg_sel

  assign tx_byte = reg_sel(ptr_ff, nb_ff, core_ff, psave_ff);

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_resetn)
    begin
      state_ff <= IMP_IDLE;
      shift_ff <= 8'h00;
      bit_cnt_ff <= 4'h0;
      rd_ff <= 1'b0;
      idx_phase_ff <= 1'b0;
      sda_oe_n_ff <= 1'b1;
    end
    else if (start_seen)
    begin
      state_ff <= IMP_ADDR;
      bit_cnt_ff <= 4'h0;
      sda_oe_n_ff <= 1'b1;
    end
    else if (stop_seen)
    begin
      state_ff <= IMP_IDLE;
      sda_oe_n_ff <= 1'b1;
    end
    else
    begin
      case (state_ff)
        IMP_IDLE: sda_oe_n_ff <= 1'b1;
        IMP_ADDR, IMP_RX:
        begin
          if (scl_rise)
          begin
            shift_ff <= {shift_ff[6:0], sda_sync_ff[1]};
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
          end
          else if (scl_fall && bit_cnt_ff == 4'h8)
          begin
            bit_cnt_ff <= 4'h0;
            if (state_ff == IMP_ADDR)
            begin
              if (shift_ff[7:1] == imp_pkg::SLAVE_ADDR)
              begin
                rd_ff <= shift_ff[0];
                idx_phase_ff <= 1'b1;
                sda_oe_n_ff <= 1'b0;
                state_ff <= IMP_ADDR_ACK;
              end
              else
                state_ff <= IMP_IDLE;
            end
            else
            begin
              sda_oe_n_ff <= 1'b0;
              state_ff <= IMP_RX_ACK;
            end
          end
        end
        IMP_ADDR_ACK, IMP_RX_ACK:
        begin
          if (scl_fall)
          begin
            if (state_ff == IMP_RX_ACK)
              idx_phase_ff <= 1'b0;
            if (rd_ff && state_ff == IMP_ADDR_ACK)
            begin
              // data from the pointer kept since the index write
              shift_ff <= tx_byte;
              sda_oe_n_ff <= tx_byte[7];
              bit_cnt_ff <= 4'h1;
              state_ff <= IMP_TX;
            end
            else
            begin
              sda_oe_n_ff <= 1'b1;
              state_ff <= IMP_RX;
            end
          end
        end
        IMP_TX:
        begin
          if (scl_fall)
          begin
            if (bit_cnt_ff == 4'h8)
            begin
              sda_oe_n_ff <= 1'b1;
              state_ff <= IMP_TX_ACK;
            end
            else
            begin
              // msb first; oe low drives a zero
              sda_oe_n_ff <= shift_ff[6];
              shift_ff <= {shift_ff[6:0], 1'b0};
              bit_cnt_ff <= bit_cnt_ff + 4'h1;
            end
          end
        end
        IMP_TX_ACK:
        begin
          if (scl_rise)
          begin
            // nack ends the read; wait for stop
            if (sda_sync_ff[1])
              state_ff <= IMP_IDLE;
          end
          else if (scl_fall)
          begin
            shift_ff <= tx_byte;
            sda_oe_n_ff <= tx_byte[7];
            bit_cnt_ff <= 4'h1;
            state_ff <= IMP_TX;
          end
        end
        default: state_ff <= IMP_IDLE;
      endcase
    end
  end

  // a data byte received while not in the index phase is a register write
  assign wr_en = state_ff == IMP_RX && scl_fall && bit_cnt_ff == 4'h8
                 && !idx_phase_ff && !start_seen && !stop_seen;
  assign wr_data = shift_ff;

  //////////////////////////////////////////////////////////////////////////////
  // register pointer
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_resetn)
      ptr_ff <= imp_pkg::IDX_NB;
    else if (state_ff == IMP_RX && scl_fall && bit_cnt_ff == 4'h8
             && idx_phase_ff && !start_seen && !stop_seen)
      ptr_ff <= shift_ff;
    else if (wr_en && ptr_ff < imp_pkg::IDX_PSAVE)
      ptr_ff <= ptr_ff + 8'h01;
    else if (state_ff == IMP_TX_ACK && scl_rise && !sda_sync_ff[1]
             && ptr_ff < imp_pkg::IDX_PSAVE)
      ptr_ff <= ptr_ff + 8'h01;
  end

  //////////////////////////////////////////////////////////////////////////////
  // register file, held at defaults while the supply is low
  always_ff @(posedge i_clk_sys)
  begin
    if (por_hold)
    begin
      nb_ff <= imp_pkg::RST_NB;
      core_ff <= imp_pkg::RST_CORE;
      psave_ff <= imp_pkg::RST_PSAVE;
    end
    else if (wr_en)
    begin
      // plain store; writing defaults is a soft reset only
      if (ptr_ff == imp_pkg::IDX_NB)
        nb_ff <= wr_data;
      else if (ptr_ff == imp_pkg::IDX_CORE)
        core_ff <= wr_data;
      else if (ptr_ff == imp_pkg::IDX_PSAVE)
        psave_ff <= wr_data;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // registered outputs
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_resetn)
    begin
      o_nb_rail <= rail_decode(imp_pkg::RST_NB, 1'b0);
      o_core_rail <= rail_decode(imp_pkg::RST_CORE, 1'b1);
      o_psave <= '0;
      o_nb_reg <= imp_pkg::RST_NB;
      o_core_reg <= imp_pkg::RST_CORE;
      o_psave_reg <= imp_pkg::RST_PSAVE;
    end
    else
    begin
      o_nb_rail <= rail_decode(nb_ff, 1'b0);
      o_core_rail <= rail_decode(core_ff, 1'b1);
      // 1x means three phases
      o_psave.phases <= psave_ff[imp_pkg::PS_PH_LSB + 1] ? 2'h3
                        : (psave_ff[imp_pkg::PS_PH_LSB] ? 2'h2 : 2'h1);
      o_psave.drop_cycles <=
        space_decode(psave_ff[imp_pkg::PS_DROP_LSB +: 2]);
      o_psave.add_cycles <=
        space_decode(psave_ff[imp_pkg::PS_ADD_LSB +: 2]);
      o_psave.offset_off <= psave_ff[imp_pkg::PS_OFS_OFF_BIT];
      // bit 7 has no consumer
      o_nb_reg <= nb_ff;
      o_core_reg <= core_ff;
      o_psave_reg <= psave_ff;
    end
  end

  assign o_sda_oe_n = sda_oe_n_ff;

endmodule : imp_regs

// >>> imp_regs_sva.sv
// assertion checker for the register port outputs
`timescale 1ns/1ps
module imp_regs_chk (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  // supply and link
  input wire logic i_supply_por,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic o_sda_oe_n,
  // decoded and raw views
  input wire imp_pkg::imp_rail_t o_nb_rail,
  input wire imp_pkg::imp_rail_t o_core_rail,
  input wire imp_pkg::imp_psave_t o_psave,
  input wire logic [7:0] o_nb_reg,
  input wire logic [7:0] o_core_reg,
  input wire logic [7:0] o_psave_reg
);
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_resetn);
  wire logic dflt = o_nb_reg == 8'h00 && o_core_reg == 8'h00
    && o_psave_reg == 8'h01;
  // code 3 means all at once
  function automatic logic [2:0] gap(input logic [1:0] c);
    return (c == 2'h3) ? 3'h0 : 3'h1 << c;
  endfunction : gap
////////////////////////////////////////////////////////////////////////////////
  reset_vals_a:
    assert property ($rose(i_resetn) |-> dflt)
    else $error("defaults missing after reset");
  por_hold_a:
    // two sync stages, register load, then output stage
    assert property (i_supply_por [*6] |-> dflt)
    else $error("supply reset kept old values");
  sda_scl_low_a:
    assert property ($changed(o_sda_oe_n) |-> !i_scl && !$past(i_scl, 2))
    else $error("data line moved while clock high");
  nb_ovp_a:
    assert property ($stable(o_nb_reg) [*3] |->
      o_nb_rail.ovp_add_mv == (o_nb_reg[7] ? 12'h1F4 : 12'h0FA)
      && o_nb_rail.ovp_floor_mv == 12'h708)
    else $error("north bridge trip level wrong");
  core_pg_a:
    assert property ($stable(o_core_reg) [*3] |->
      o_core_rail.pg_up_mv == (o_core_reg[6] ? 12'h12C : 12'h0FA)
      && o_core_rail.pg_dn_mv == (o_core_reg[6] ? 12'h15E : 12'h12C)
      && o_core_rail.ovp_add_mv == (o_core_reg[7] ? 12'h1F4 : 12'h0FA)
      && o_core_rail.pg_hyst_mv == 12'h032)
    else $error("core window wrong");
  nb_pg_a:
    assert property ($stable(o_nb_reg) [*3] |-> o_nb_rail.pg_up_mv == 12'h000
      && o_nb_rail.pg_dn_mv == (o_nb_reg[6] ? 12'h15E : 12'h12C))
    else $error("north bridge window wrong");
  nb_offset_a:
    assert property ($stable(o_nb_reg) [*3] |->
      $signed(o_nb_rail.offset_mv) == $signed(o_nb_reg[5:0]) * 12'sh019)
    else $error("offset decode wrong");
  psave_phases_a:
    assert property ($stable(o_psave_reg) [*3] |-> o_psave.phases ==
      (o_psave_reg[1] ? 2'h3 : (o_psave_reg[0] ? 2'h2 : 2'h1)))
    else $error("phase count wrong");
  psave_steps_a:
    assert property ($stable(o_psave_reg) [*3] |->
      o_psave.drop_cycles == gap(o_psave_reg[5:4])
      && o_psave.add_cycles == gap(o_psave_reg[3:2])
      && o_psave.offset_off == o_psave_reg[6])
    else $error("power save steps wrong");
endmodule : imp_regs_chk
bind imp_regs imp_regs_chk chk (.*);

// >>> imp_bus_master.sv
// behavioural two-wire bus master, paced by the system clock
`timescale 1ns/1ps
module imp_bus_master (
  // pacing clock
  input wire logic i_clk,
  // resolved data line
  input wire logic i_sda,
  // link outputs, idle high
  output logic o_scl,
  output logic o_sda_oe_n
);
  // 128 ns bit: nearest whole-cycle fit to the 125 ns link period
  localparam int QTR = 4;
  initial
  begin
    o_scl = 1'b1;
    o_sda_oe_n = 1'b1;
  end
////////////////////////////////////////////////////////////////////////////////
  task automatic wait_q();
    repeat (QTR) @(posedge i_clk);
  endtask : wait_q
  task automatic bit_io(input logic b, output logic s);
    o_sda_oe_n <= b;
    wait_q();
    o_scl <= 1'b1;
    wait_q();
    s = i_sda;
    wait_q();
    o_scl <= 1'b0;
    wait_q();
  endtask : bit_io
  task automatic start();
    o_sda_oe_n <= 1'b1;
    wait_q();
    o_scl <= 1'b1;
    wait_q();
    o_sda_oe_n <= 1'b0;
    wait_q();
    o_scl <= 1'b0;
    wait_q();
  endtask : start
  task automatic stop();
    o_sda_oe_n <= 1'b0;
    wait_q();
    o_scl <= 1'b1;
    wait_q();
    o_sda_oe_n <= 1'b1;
    wait_q();
  endtask : stop
  // ninth bit: 1 releases the line, 0 acknowledges a read byte
  task automatic xfer(input logic [7:0] tx, input logic last,
                      output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--)
      bit_io(tx[i], rx[i]);
    bit_io(last, ack);
  endtask : xfer
endmodule : imp_bus_master

// >>> imp_regs_tb_top.sv
// self-checking bench for the register port
`timescale 1ns/1ps
module imp_regs_tb_top;
  logic i_clk_sys;
  logic i_resetn = 1'b0;
  logic i_supply_por = 1'b0;
  logic scl;
  logic m_oe_n;
  logic o_sda_oe_n;
  logic nack;
  logic [7:0] nb_reg, core_reg, ps_reg;
  logic [7:0] q [4];
  int num_errors = 0;
  int n_tests = 0;
  // rows: north bridge, core, power save
  logic [7:0] rows [4][3] = '{'{8'h80, 8'h40, 8'h00},
    '{8'h20, 8'hDF, 8'h15}, '{8'h00, 8'h00, 8'h7F}, '{8'h3F, 8'h01, 8'hEA}};
  // pull-up makes the line a wired and
  wire logic sda = m_oe_n & o_sda_oe_n;
  imp_regs uut (
    .i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn),
    .i_supply_por(i_supply_por),
    .i_scl(scl),
    .i_sda(sda),
    .o_sda_oe_n(o_sda_oe_n),
    .o_nb_rail(),
    .o_core_rail(),
    .o_psave(),
    .o_nb_reg(nb_reg),
    .o_core_reg(core_reg),
    .o_psave_reg(ps_reg)
  );
  imp_bus_master m (
    .i_clk(i_clk_sys),
    .i_sda(sda),
    .o_scl(scl),
    .o_sda_oe_n(m_oe_n)
  );
////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [7:0] seen,
                       input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic put(input logic [7:0] b);
    logic [7:0] rx;
    logic a;
    m.xfer(b, 1'b1, rx, a);
    check("ack", {7'h00, a}, 8'h00);
  endtask : put
  task automatic rd(input logic [7:0] idx, input int n);
    logic a;
    m.start();
    put({imp_pkg::SLAVE_ADDR, 1'b0});
    put(idx);
    m.stop();
    m.start();
    put({imp_pkg::SLAVE_ADDR, 1'b1});
    for (int i = 0; i < n; i++)
      m.xfer(8'hFF, i == n - 1, q[i], a);
    m.stop();
  endtask : rd
  task automatic wr3(input logic [7:0] d [3]);
    m.start();
    put({imp_pkg::SLAVE_ADDR, 1'b0});
    put(8'h00);
    foreach (d[i])
      put(d[i]);
    m.stop();
    repeat (4) @(posedge i_clk_sys);
    check("nb", nb_reg, d[0]);
    check("core", core_reg, d[1]);
    check("psave", ps_reg, d[2]);
  endtask : wr3
  task automatic close_out();
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : close_out
  initial
  begin
    i_clk_sys = 1'b0;
    forever #4 i_clk_sys = ~i_clk_sys;
  end
  initial
  begin
    repeat (60000) @(posedge i_clk_sys);
    num_errors++;
    close_out();
  end
  initial
  begin
    repeat (10) @(posedge i_clk_sys);
    i_resetn <= 1'b1;
    repeat (3) @(posedge i_clk_sys);
    check("nb", nb_reg, 8'h00);
    check("core", core_reg, 8'h00);
    check("psave", ps_reg, 8'h01);
    foreach (rows[r])
    begin
      wr3(rows[r]);
      rd(8'h00, 3);
      for (int k = 0; k < 3; k++)
        check("read", q[k], rows[r][k]);
    end
    rd(8'h01, 1);
    check("single read", q[0], 8'h01);
    rd(8'h00, 4);
    check("read past end", q[3], 8'hEA);
    m.start();
    m.xfer({imp_pkg::SLAVE_ADDR ^ 7'h01, 1'b1}, 1'b1, q[0], nack);
    check("foreign ack", {7'h00, nack}, 8'h01);
    m.stop();
    i_supply_por <= 1'b1;
    repeat (8) @(posedge i_clk_sys);
    i_supply_por <= 1'b0;
    repeat (4) @(posedge i_clk_sys);
    check("nb", nb_reg, 8'h00);
    check("core", core_reg, 8'h00);
    check("psave", ps_reg, 8'h01);
    wr3(rows[1]);
    wr3('{8'h00, 8'h00, 8'h01});
    close_out();
  end
endmodule : imp_regs_tb_top
